// ### rtl/sfo_pkg.sv
/*
 Package for the sync-request filter and over-range register bank.
 Assumes a single 125 MHz clock standing in for the link clock (half the sample rate).
*/
package sfo_pkg;
    // Register addresses on the serial control port
    localparam logic [11:0] SFO_ADDR_SYNC_FILTER = 12'h210;
    localparam logic [11:0] SFO_ADDR_OVR_LEVEL = 12'h211;
    localparam logic [11:0] SFO_ADDR_OVR_CONFIG = 12'h213;
    localparam logic [11:0] SFO_ADDR_STARTUP = 12'h270;
    localparam logic [11:0] SFO_ADDR_POWER_TWO = 12'h29a;
    // Reset values
    localparam logic [7:0] SFO_RST_SYNC_FILTER = 8'h03;
    localparam logic [7:0] SFO_RST_OVR_LEVEL = 8'hf2;
    localparam logic [7:0] SFO_RST_OVR_CONFIG = 8'h07;
    localparam logic [7:0] SFO_RST_POWER_TWO = 8'h0f;
    // Field layout
    localparam int SFO_LIMIT_W = 5;
    localparam int SFO_OVERRANGE_OUTPUT_ENABLE_BIT = 3;
    localparam int SFO_EXP_W = 3;
    localparam int SFO_CHANNELS = 4;
    localparam int SFO_SAMPLE_W = 12;
    // Sample magnitude bits compared against the 8-bit level (level/256 of full scale)
    localparam int SFO_MAG_SHIFT = 3;
    // Base stretch of 4 sampling cycles, two samples per link clock
    localparam logic [9:0] SFO_STRETCH_BASE_CLK = 10'h002;
    // Cycles spent initialising after reset before startup-complete reads 1
    localparam logic [7:0] SFO_INIT_CYCLES = 8'h40;
endpackage : sfo_pkg

// ### rtl/sfo_link_if.sv
/*
 Interface joining the device end and the host end.
 Assumes both ends share sys_clk; the testbench drives sample data.
*/
`timescale 1ns/100ps
`default_nettype none
interface sfo_link_if;
    // Serial control port, one access per strobe
    logic cmd_valid;
    logic cmd_write;
    logic [11:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    // Link request and over-range flags
    logic sync_request_n;
    logic [3:0] overrange_flags;

    modport device (
        input cmd_valid, cmd_write, cmd_addr, cmd_wdata, sync_request_n,
        output rsp_valid, rsp_rdata, overrange_flags
    );
    modport host (
        output cmd_valid, cmd_write, cmd_addr, cmd_wdata, sync_request_n,
        input rsp_valid, rsp_rdata, overrange_flags
    );
endinterface : sfo_link_if
`default_nettype wire

// ### rtl/sfo_device.sv
/*
 Device end: register bank, sync-request filter, four-channel over-range detect and stretch.
 Assumes sys_clk is the link clock; samples arrive as signed words, one per channel per clock.
*/
// How it works
// - Sync request after limit plus one low samples
// - Sample sync request on the link clock
// - Shorter low pulses ignored as error reports
// - Software changes limit only while link disabled
// - Receiver disables error reporting, limit zero recommended
// - Software writes zero to reserved bits
// - Flag when magnitude reaches level threshold
// - Flags held low unless output enable set
// - Stretch flags 4 times two to exponent samples
// - Startup-complete reads one after initialisation
// - Host waits for startup-complete before accesses
`timescale 1ns/100ps
`default_nettype none
module sfo_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link and control port
    sfo_link_if.device link,
    // Sample inputs, channel a in the low bits
    input wire logic [47:0] sample_data,
    // Link control and over-range flags
    input wire logic serial_link_enable,
    output logic sync_request_q,
    output logic overrange_flag_a,
    output logic overrange_flag_b,
    output logic overrange_flag_c,
    output logic overrange_flag_d
);
    logic [7:0] sync_request_filter_q;
    logic [7:0] overrange_level_q;
    logic [7:0] overrange_config_q;
    logic [7:0] power_profile_two_q;
    logic startup_done_q;
    logic [7:0] init_cnt_q;
    logic [5:0] low_cnt_q;
    logic [3:0] flag_q;
    logic rsp_valid_q;
    logic [7:0] rsp_rdata_q;
    logic [9:0] stretch_len;
    logic [7:0] rdata_d;

    // Register writes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_request_filter_q <= sfo_pkg::SFO_RST_SYNC_FILTER;
            overrange_level_q <= sfo_pkg::SFO_RST_OVR_LEVEL;
            overrange_config_q <= sfo_pkg::SFO_RST_OVR_CONFIG;
            power_profile_two_q <= sfo_pkg::SFO_RST_POWER_TWO;
        end else if (link.cmd_valid && link.cmd_write) begin
            unique case (link.cmd_addr)
                sfo_pkg::SFO_ADDR_SYNC_FILTER: sync_request_filter_q <= link.cmd_wdata;
                sfo_pkg::SFO_ADDR_OVR_LEVEL: overrange_level_q <= link.cmd_wdata;
                sfo_pkg::SFO_ADDR_OVR_CONFIG: overrange_config_q <= link.cmd_wdata;
                sfo_pkg::SFO_ADDR_POWER_TWO: power_profile_two_q <= link.cmd_wdata;
                default: ;
            endcase
        end
    end

    // Read data mux; unmapped addresses read zero
    always_comb begin
        unique case (link.cmd_addr)
            sfo_pkg::SFO_ADDR_SYNC_FILTER: rdata_d = sync_request_filter_q;
            sfo_pkg::SFO_ADDR_OVR_LEVEL: rdata_d = overrange_level_q;
            sfo_pkg::SFO_ADDR_OVR_CONFIG: rdata_d = overrange_config_q;
            sfo_pkg::SFO_ADDR_STARTUP: rdata_d = {7'h00, startup_done_q};
            sfo_pkg::SFO_ADDR_POWER_TWO: rdata_d = power_profile_two_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read answer one clock after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
        end else begin
            rsp_valid_q <= link.cmd_valid && !link.cmd_write;
            rsp_rdata_q <= (link.cmd_valid && !link.cmd_write) ? rdata_d : 8'h00;
        end
    end
    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_rdata = rsp_rdata_q;

    // Initialisation sequencer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            init_cnt_q <= 8'h00;
            startup_done_q <= 1'b0;
        end else if (!startup_done_q) begin
            init_cnt_q <= init_cnt_q + 8'h01;
            startup_done_q <= (init_cnt_q == sfo_pkg::SFO_INIT_CYCLES - 8'h01);
        end
    end

    // Consecutive-low counter on the link clock; a short low is dropped
    always_ff @(posedge sys_clk) begin
        if (srst || !serial_link_enable) begin
            low_cnt_q <= 6'h00;
            sync_request_q <= 1'b0;
        end else if (link.sync_request_n) begin
            low_cnt_q <= 6'h00;
            sync_request_q <= 1'b0;
        end else begin
            if (low_cnt_q <= {1'b0, sync_request_filter_q[sfo_pkg::SFO_LIMIT_W-1:0]}) begin
                low_cnt_q <= low_cnt_q + 6'h01;
            end
            // Request once limit+1 lows have been seen
            sync_request_q <= (low_cnt_q >= {1'b0, sync_request_filter_q[sfo_pkg::SFO_LIMIT_W-1:0]});
        end
    end

    // Stretch length in link clocks: 2 * 2^exp
    assign stretch_len = sfo_pkg::SFO_STRETCH_BASE_CLK << overrange_config_q[sfo_pkg::SFO_EXP_W-1:0];

    // One detector per channel
    genvar ch;
    generate
        for (ch = 0; ch < sfo_pkg::SFO_CHANNELS; ch++) begin : g_chan
            logic [11:0] smp;
            logic [10:0] mag;
            logic hit;
            logic [9:0] hold_q;
            assign smp = sample_data[ch*sfo_pkg::SFO_SAMPLE_W +: sfo_pkg::SFO_SAMPLE_W];
            assign mag = smp[11] ? 11'(~smp[10:0]) : smp[10:0];
            assign hit = (mag[10:sfo_pkg::SFO_MAG_SHIFT] >= overrange_level_q);
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    hold_q <= 10'h000;
                    flag_q[ch] <= 1'b0;
                end else begin
                    if (hit) begin
                        hold_q <= stretch_len - 10'h001;
                    end else if (hold_q != 10'h000) begin
                        hold_q <= hold_q - 10'h001;
                    end
                    flag_q[ch] <= overrange_config_q[sfo_pkg::SFO_OVERRANGE_OUTPUT_ENABLE_BIT] &&
                        (hit || hold_q != 10'h000);
                end
            end
        end
    endgenerate

    assign link.overrange_flags = flag_q;
    assign overrange_flag_a = flag_q[0];
    assign overrange_flag_b = flag_q[1];
    assign overrange_flag_c = flag_q[2];
    assign overrange_flag_d = flag_q[3];
endmodule // sfo_device
`default_nettype wire

// ### rtl/sfo_host.sv
/*
 Host end: waits for startup-complete, then forwards user accesses; drives the sync request line.
 Assumes the device answers reads one clock after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module sfo_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link
    sfo_link_if.host link,
    // User request
    input wire logic user_valid,
    input wire logic user_write,
    input wire logic [11:0] user_addr,
    input wire logic [7:0] user_wdata,
    input wire logic user_sync_request,
    // User answer
    output logic user_ready_q,
    output logic user_rvalid_q,
    output logic [7:0] user_rdata_q,
    output logic [3:0] user_flags_q
);
    typedef enum logic [1:0] {SFO_POLL, SFO_WAIT, SFO_RUN} sfo_host_state_t;
    sfo_host_state_t state_q;
    logic cmd_valid_q;
    logic cmd_write_q;
    logic [11:0] cmd_addr_q;
    logic [7:0] cmd_wdata_q;
    logic sync_n_q;

    // Poll startup-complete before any other access
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= SFO_POLL;
            cmd_valid_q <= 1'b0;
            cmd_write_q <= 1'b0;
            cmd_addr_q <= 12'h000;
            cmd_wdata_q <= 8'h00;
            user_ready_q <= 1'b0;
        end else begin
            cmd_valid_q <= 1'b0;
            unique case (state_q)
                SFO_POLL: begin
                    cmd_valid_q <= 1'b1;
                    cmd_write_q <= 1'b0;
                    cmd_addr_q <= sfo_pkg::SFO_ADDR_STARTUP;
                    state_q <= SFO_WAIT;
                end
                SFO_WAIT: begin
                    if (link.rsp_valid) begin
                        state_q <= link.rsp_rdata[0] ? SFO_RUN : SFO_POLL;
                        user_ready_q <= link.rsp_rdata[0];
                    end
                end
                SFO_RUN: begin
                    // Reserved bits are zeroed on the way out
                    if (user_valid) begin
                        cmd_valid_q <= 1'b1;
                        cmd_write_q <= user_write;
                        cmd_addr_q <= user_addr;
                        unique case (user_addr)
                            sfo_pkg::SFO_ADDR_SYNC_FILTER: cmd_wdata_q <= user_wdata & 8'h1f;
                            sfo_pkg::SFO_ADDR_OVR_CONFIG: cmd_wdata_q <= user_wdata & 8'h0f;
                            default: cmd_wdata_q <= user_wdata;
                        endcase
                    end
                end
            endcase
        end
    end

    // Answer and sync line
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            user_rvalid_q <= 1'b0;
            user_rdata_q <= 8'h00;
            user_flags_q <= 4'h0;
            sync_n_q <= 1'b1;
        end else begin
            user_rvalid_q <= link.rsp_valid && state_q == SFO_RUN;
            user_rdata_q <= link.rsp_rdata;
            user_flags_q <= link.overrange_flags;
            sync_n_q <= !user_sync_request;
        end
    end

    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_write = cmd_write_q;
    assign link.cmd_addr = cmd_addr_q;
    assign link.cmd_wdata = cmd_wdata_q;
    assign link.sync_request_n = sync_n_q;
endmodule // sfo_host
`default_nettype wire

// ### verification/sfo_link_monitor.sv
/* Checker on the link between the host and device ends.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module sfo_link_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link signals
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [11:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata,
    input wire logic [3:0] overrange_flags
);
    logic [7:0] up_q;
    logic en_q;
    logic stat_q;
    logic done_q;
    // Uptime, enable shadow, startup-complete seen
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            up_q <= 8'h00;
            en_q <= 1'b0;
            stat_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            up_q <= up_q + {7'h00, up_q != 8'hff};
            if (cmd_valid && cmd_write && cmd_addr == 12'h213) en_q <= cmd_wdata[3];
            stat_q <= cmd_valid && !cmd_write && cmd_addr == 12'h270;
            if (rsp_valid && stat_q && rsp_rdata[0]) done_q <= 1'b1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    read_answer_a: assert property (cmd_valid && !cmd_write |=> rsp_valid)
        else $error("read not answered");
    answer_cause_a: assert property (rsp_valid |-> $past(cmd_valid && !cmd_write))
        else $error("answer without read");
    idle_data_a: assert property (!rsp_valid |-> rsp_rdata == 8'h00)
        else $error("read data not cleared");
    startup_wait_a: assert property (cmd_valid && (cmd_write || cmd_addr != 12'h270) |-> done_q)
        else $error("access before startup");
    startup_read_a: assert property (rsp_valid && stat_q && up_q < 8'd62 |-> rsp_rdata == 8'h00)
        else $error("startup done too early");
    reserved_sync_a: assert property (cmd_valid && cmd_write && cmd_addr == 12'h210 |-> cmd_wdata[7:5] == 3'h0)
        else $error("reserved limit bits set");
    reserved_cfg_a: assert property (cmd_valid && cmd_write && cmd_addr == 12'h213 |-> cmd_wdata[7:4] == 4'h0)
        else $error("reserved config bits set");
    flag_gate_a: assert property (!en_q && !$past(en_q) |-> overrange_flags == 4'h0)
        else $error("flag while disabled");
    stretch_min_a: assert property ($rose(overrange_flags[0]) |-> overrange_flags[0] [*2])
        else $error("flag pulse too short");
endmodule // sfo_link_monitor
`default_nettype wire

// ### verification/tb_sync_filter_overrange_regs.sv
/* Bench joining both ends: registers, sync filter, over-range flags.
   Assumes the rtl package and interface are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_sync_filter_overrange_regs;
    logic sys_clk = 0, srst = 1, user_valid = 0, user_write = 0, user_sync_request = 0, serial_link_enable = 0;
    logic [11:0] user_addr = 0;
    logic [7:0] user_wdata = 0, user_rdata_q;
    logic [47:0] sample_data = 0;
    logic user_ready_q, user_rvalid_q, sync_request_q, seen;
    logic [3:0] fl, hf;
    logic [7:0] mdl [int];
    logic [31:0] rng = 92228;
    int n_fail = 0, checks = 0, i, k, e, lim, own, oth, ownh;
    int adr[6] = '{'h210, 'h211, 'h213, 'h29a, 'h270, 'h3ff};
    sfo_link_if link ();
    sfo_device u_sfo_device (.sys_clk, .srst, .link(link), .sample_data, .serial_link_enable, .sync_request_q,
        .overrange_flag_a(fl[0]), .overrange_flag_b(fl[1]), .overrange_flag_c(fl[2]), .overrange_flag_d(fl[3]));
    sfo_host u_sfo_host (.sys_clk, .srst, .link(link), .user_valid, .user_write, .user_addr, .user_wdata,
        .user_sync_request, .user_ready_q, .user_rvalid_q, .user_rdata_q, .user_flags_q(hf));
    sfo_link_monitor u_sfo_link_monitor (.sys_clk, .srst, .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write),
        .cmd_addr(link.cmd_addr), .cmd_wdata(link.cmd_wdata), .rsp_valid(link.rsp_valid),
        .rsp_rdata(link.rsp_rdata), .overrange_flags(link.overrange_flags));
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task close_out();
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One host access; writes update the model, reads are compared with it
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        int j;
        @(posedge sys_clk);
        user_valid <= 1'b1;
        user_write <= w;
        user_addr <= a;
        user_wdata <= d;
        @(posedge sys_clk);
        user_valid <= 1'b0;
        if (w) begin
            if (mdl.exists(a) && a != 12'h270) mdl[a] = d & (a == 12'h210 ? 8'h1f : a == 12'h213 ? 8'h0f : 8'hff);
            repeat (4) @(posedge sys_clk);
        end else begin
            for (j = 0; j < 20 && user_rvalid_q !== 1'b1; j++) @(posedge sys_clk);
            if (j == 20) begin
                n_fail++;
                close_out();
            end
            chk(user_rdata_q, mdl.exists(a) ? mdl[a] : 8'h00);
        end
    endtask
    // Low request for n cycles; note any filtered request
    task sync_pulse(input int n);
        int j;
        seen = 1'b0;
        for (j = 0; j < n + 8; j++) begin
            @(posedge sys_clk);
            user_sync_request <= (j < n);
            seen = seen | sync_request_q;
        end
    endtask
    // One-cycle sample on channel c; count own and foreign flag cycles
    task orun(input int c, input logic [11:0] s);
        int j;
        own = 0;
        oth = 0;
        ownh = 0;
        @(posedge sys_clk);
        sample_data <= {36'h0, s} << (12 * c);
        @(posedge sys_clk);
        sample_data <= 48'h0;
        for (j = 0; j < 40; j++) begin
            @(posedge sys_clk);
            own += int'(fl[c] === 1'b1);
            ownh += int'(hf[c] === 1'b1);
            oth += int'((fl & ~(4'h1 << c)) !== 4'h0);
        end
    endtask
    // Main sequence
    initial begin
        mdl = '{'h210: 8'h03, 'h211: 8'hf2, 'h213: 8'h07, 'h29a: 8'h0f, 'h270: 8'h01};
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        for (i = 0; i < 200 && user_ready_q !== 1'b1; i++) @(posedge sys_clk);
        if (i == 200) begin
            n_fail++;
            close_out();
        end
        chk(8'(i >= 60), 8'h01);
        foreach (adr[k]) acc(1'b0, 12'(adr[k]), 8'h00);
        foreach (adr[k]) acc(1'b1, 12'(adr[k]), 8'(rnd()));
        foreach (adr[k]) acc(1'b0, 12'(adr[k]), 8'h00);
        for (k = 0; k < 2; k++) begin
            lim = k ? int'(rnd() % 32) : 0;
            serial_link_enable <= 1'b0;
            acc(1'b1, 12'h210, 8'(lim));
            serial_link_enable <= 1'b1;
            sync_pulse(lim);
            chk({7'h0, seen}, 8'h00);
            sync_pulse(lim + 1);
            chk({7'h0, seen}, 8'h01);
        end
        acc(1'b1, 12'h211, 8'h40);
        for (e = 0; e < 4; e++) begin
            acc(1'b1, 12'h213, e < 3 ? 8'(8 + e) : 8'h00);
            for (k = 0; k < 4; k++) begin
                orun(k, 12'h1f8);
                chk(8'(own + oth), 8'h00);
                orun(k, k[0] ? 12'hdff : 12'h200);
                chk(8'(own >= (2 << e) && own <= (2 << e) + 2), 8'(e < 3));
                chk(8'(oth), 8'h00);
                chk(8'(ownh), 8'(own));
            end
        end
        close_out();
    end
endmodule // tb_sync_filter_overrange_regs
`default_nettype wire
